// ===== logic/mb_pkg.sv
// Shared constants, carrier types and CRC helper for the serial frame engine
package mb_pkg;

   // Checksum
   localparam logic [15:0] CRC_INIT    = 16'hffff;
   localparam logic [15:0] CRC_POLY    = 16'ha001;

   // Station addressing
   localparam logic [7:0]  ADDR_BCAST  = 8'h00;
   localparam logic [7:0]  ADDR_MAX    = 8'hf7;

   // Function codes and exception codes
   localparam logic [7:0]  FN_READ     = 8'h03;
   localparam logic [7:0]  FN_WRITE    = 8'h06;
   localparam logic [7:0]  EXC_FLAG    = 8'h80;
   localparam logic [7:0]  EXC_BAD_FN  = 8'h01;
   localparam logic [7:0]  EXC_BAD_ADR = 8'h02;
   localparam logic [7:0]  EXC_BAD_DAT = 8'h03;
   localparam logic [7:0]  EXC_FAIL    = 8'h04;
   localparam logic [7:0]  EXC_NONE    = 8'h00;

   // Frame shape: address, function, four data bytes, two check bytes
   localparam logic [7:0]  REQ_LEN     = 8'h08;
   localparam logic [7:0]  MIN_LEN     = 8'h04;
   localparam logic [2:0]  ECHO_LEN    = 3'h6;
   localparam logic [2:0]  SHORT_LEN   = 3'h3;

   // Character timing in half-bit units; one character is 11 bit times
   localparam int          CHAR_BITS   = 11;
   localparam logic [7:0]  T15_HALF    = 8'(3 * CHAR_BITS);
   localparam logic [7:0]  T35_HALF    = 8'(7 * CHAR_BITS);

   typedef enum logic [2:0] {
      S_IDLE    = 3'b000,
      S_EVAL    = 3'b001,
      S_WRITE   = 3'b010,
      S_HDR     = 3'b011,
      S_RD_REQ  = 3'b100,
      S_RD_WORD = 3'b101,
      S_CRC     = 3'b110,
      S_DRAIN   = 3'b111
   } state_type;

   typedef struct packed {
      logic        req;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } param_req_type;

   typedef struct packed {
      logic        ack;
      logic [7:0]  exc;
      logic [15:0] rdata;
   } param_rsp_type;

   // One byte through the reflected CRC-16, LSB first
   function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : crc_byte

endpackage : mb_pkg

// ===== logic/tx_skid_buf.sv
// Two-entry byte buffer between the frame engine and the serial transmitter
`timescale 1ns/1ps
`default_nettype none
module tx_skid_buf #(
   parameter int WIDTH = 8
)(
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   // Filling side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Draining side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o,
   // Status
   output logic                  empty_o
);

   logic             spare_valid_ff;
   logic [WIDTH-1:0] spare_data_ff;
   logic             push;
   logic             pop;

   assign push       = in_valid_i && in_ready_o;
   assign pop        = out_valid_o && out_ready_i;
   // Ready comes from a flop, so a stalled receiver never forms a long path
   assign in_ready_o = !spare_valid_ff;
   assign empty_o    = !out_valid_o && !spare_valid_ff;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         out_valid_o    <= 1'b0;
         out_data_o     <= '0;
         spare_valid_ff <= 1'b0;
         spare_data_ff  <= '0;
      end else if (!out_valid_o || pop) begin
         if (spare_valid_ff) begin
            out_data_o     <= spare_data_ff;
            out_valid_o    <= 1'b1;
            spare_valid_ff <= 1'b0;
         end else begin
            out_valid_o <= push;
            if (push) begin
               out_data_o <= in_data_i;
            end
         end
      end else if (push) begin
         spare_data_ff  <= in_data_i;
         spare_valid_ff <= 1'b1;
      end
   end

endmodule : tx_skid_buf
`default_nettype wire

// ===== logic/modbus_rtu_slave_framer.sv
// Serial slave frame engine: gap framing, address filter, read/write parsing, replies
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Drive enable rises only for our own reply; otherwise we only listen.
// - Accept frames for our own station address or broadcast address zero.
// - Transmit only as the answer to a received request, never unprompted.
// - Every valid individually addressed request gets a reply frame.
// - Broadcast writes are carried out but never answered; broadcast reads are dropped.
// - A silence of 3.5 characters ends a message; replies start after it.
// - Bus is watched always; first byte after a gap is the address.
// - Silence over 1.5 characters mid-frame abandons it; next byte is address.
// - Bytes arriving within the gap are appended and later fail the check.
// - Function 03H reads parameters, 06H writes one parameter.
// - Read request: address, 03H, start address, count, check bytes.
// - Read reply echoes address, function, count times two, words high first.
// - Write request carries address and value; success echoes it exactly.
// - Two check bytes close each frame; receiver recomputes and flags mismatch.
// - Checksum starts at ffff each frame, over the eight data bits only.
// - Per byte: xor in, then eight right shifts with conditional polynomial xor.
// - Check value is sent low byte first, then high byte.
// - Request problems, and store errors on a write or a read's first word, in addressed frames that pass the check get an exception reply; check failures get none.
// - Exception reply: address, function plus 80h, one code, check bytes.
module modbus_rtu_slave_framer
   import mb_pkg::*;
#(
   parameter int MAX_WORDS = 125
)(
   // Clock and reset
   input  wire logic          mclk_i,
   input  wire logic          rst_i,
   // Configuration
   input  wire logic [7:0]    own_addr_i,
   input  wire logic [15:0]   half_bit_div_i,
   // Received bytes
   input  wire logic [7:0]    rx_data_i,
   input  wire logic          rx_valid_i,
   // Transmit bytes
   output logic [7:0]         tx_data_o,
   output logic               tx_valid_o,
   input  wire logic          tx_ready_i,
   input  wire logic          tx_idle_i,
   output logic               drive_en_o,
   // Parameter store
   output var param_req_type  param_o,
   input  wire param_rsp_type param_rsp_i,
   // Status pulses
   output logic               frame_ok_o,
   output logic               crc_err_o
);

   state_type         state_ff;
   logic [15:0]       div_cnt_ff, rx_crc_ff, tx_crc_ff, word_ff;
   logic [7:0]        gap_cnt_ff, rx_cnt_ff, words_ff;
   logic [7:0]        rx_buf_ff [REQ_LEN];
   logic [5:0][7:0]   hdr_ff;
   logic [2:0]        idx_ff, hdr_len_ff;
   logic              half_tick_ff, frame_open_ff, first_ff, is_read_ff, bcast_ff;
   logic              drive_en_ff, frame_ok_ff, crc_err_ff;

   logic              gap15, end_evt, rx_take, rx_start;
   logic              crc_ok, is_bcast, accept;
   logic [7:0]        eval_code, push_byte;
   logic [15:0]       rq_addr, rq_val;
   logic              push_valid, push, buf_in_ready, buf_empty;

   function automatic logic [5:0][7:0] exc_hdr(input logic [7:0] addr, input logic [7:0] fn,
                                                input logic [7:0] code);
      return {8'h00, 8'h00, 8'h00, code, fn | EXC_FLAG, addr};
   endfunction : exc_hdr

   // Half-bit enable; divisor must be at least one
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt_ff   <= 16'h0000;
         half_tick_ff <= 1'b0;
      end else begin
         half_tick_ff <= (div_cnt_ff == 16'h0000);
         div_cnt_ff   <= (div_cnt_ff == 16'h0000) ? half_bit_div_i - 16'h0001 : div_cnt_ff - 16'h0001;
      end
   end

   // Silence timer, cleared by every byte even while we answer
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_cnt_ff <= T35_HALF;
      end else if (rx_valid_i) begin
         gap_cnt_ff <= 8'h00;
      end else if (half_tick_ff && gap_cnt_ff < T35_HALF) begin
         gap_cnt_ff <= gap_cnt_ff + 8'h01;
      end
   end

   assign gap15    = gap_cnt_ff >= T15_HALF;
   assign end_evt  = frame_open_ff && half_tick_ff && !rx_valid_i
                     && gap_cnt_ff == T35_HALF - 8'h01;
   // Bytes are only collected while idle; our own echo is ignored
   assign rx_take  = rx_valid_i && state_ff == S_IDLE;
   assign rx_start = rx_take && (!frame_open_ff || gap15);

   // Receive collection
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_open_ff <= 1'b0;
         rx_cnt_ff     <= 8'h00;
         rx_crc_ff     <= CRC_INIT;
         for (int i = 0; i < int'(REQ_LEN); i++) begin
            rx_buf_ff[i] <= 8'h00;
         end
      end else begin
         if (end_evt) begin
            frame_open_ff <= 1'b0;
         end else if (rx_take) begin
            frame_open_ff <= 1'b1;
         end
         if (rx_start) begin
            rx_cnt_ff    <= 8'h01;
            rx_crc_ff    <= crc_byte(CRC_INIT, rx_data_i);
            rx_buf_ff[0] <= rx_data_i;
         end else if (rx_take) begin
            // Short gaps append, so a merged frame fails its check
            if (rx_cnt_ff != 8'hff) begin
               rx_cnt_ff <= rx_cnt_ff + 8'h01;
            end
            rx_crc_ff <= crc_byte(rx_crc_ff, rx_data_i);
            if (rx_cnt_ff < REQ_LEN) begin
               rx_buf_ff[rx_cnt_ff[2:0]] <= rx_data_i;
            end
         end
      end
   end

   // Good frame leaves a zero residue over data plus check bytes
   assign crc_ok   = rx_crc_ff == 16'h0000 && rx_cnt_ff >= MIN_LEN;
   assign is_bcast = rx_buf_ff[0] == ADDR_BCAST;
   assign accept   = crc_ok && (is_bcast || (rx_buf_ff[0] == own_addr_i && own_addr_i <= ADDR_MAX));
   assign rq_addr  = {rx_buf_ff[2], rx_buf_ff[3]};
   assign rq_val   = {rx_buf_ff[4], rx_buf_ff[5]};

   always_comb begin
      if (rx_buf_ff[1] != FN_READ && rx_buf_ff[1] != FN_WRITE) begin
         eval_code = EXC_BAD_FN;
      end else if (rx_cnt_ff != REQ_LEN) begin
         eval_code = EXC_BAD_DAT;
      end else if (rx_buf_ff[1] == FN_READ && (rq_val == 16'h0000 || rq_val > 16'(MAX_WORDS))) begin
         eval_code = EXC_BAD_DAT;
      end else begin
         eval_code = EXC_NONE;
      end
   end

   // Frame handling and reply sequencing
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff   <= S_IDLE;
         idx_ff     <= 3'h0;
         hdr_ff     <= '0;
         hdr_len_ff <= 3'h0;
         param_o    <= '0;
         words_ff   <= 8'h00;
         word_ff    <= 16'h0000;
         first_ff   <= 1'b0;
         is_read_ff <= 1'b0;
         bcast_ff   <= 1'b0;
      end else begin
         unique case (state_ff)
            S_IDLE: begin
               if (end_evt) begin
                  state_ff <= S_EVAL;
               end
            end
            S_EVAL: begin
               idx_ff     <= 3'h0;
               bcast_ff   <= is_bcast;
               is_read_ff <= 1'b0;
               if (!accept) begin
                  state_ff <= S_IDLE;
               end else if (eval_code != EXC_NONE) begin
                  hdr_ff     <= exc_hdr(rx_buf_ff[0], rx_buf_ff[1], eval_code);
                  hdr_len_ff <= SHORT_LEN;
                  state_ff   <= is_bcast ? S_IDLE : S_HDR;
               end else if (rx_buf_ff[1] == FN_WRITE) begin
                  for (int i = 0; i < 6; i++) begin
                     hdr_ff[i] <= rx_buf_ff[i];
                  end
                  hdr_len_ff <= ECHO_LEN;
                  param_o    <= '{req: 1'b1, wr: 1'b1, addr: rq_addr, wdata: rq_val};
                  state_ff   <= S_WRITE;
               end else if (is_bcast) begin
                  state_ff <= S_IDLE;
               end else begin
                  hdr_ff     <= {24'h000000, rq_val[6:0], 1'b0, rx_buf_ff[1], rx_buf_ff[0]};
                  hdr_len_ff <= SHORT_LEN;
                  words_ff   <= rq_val[7:0];
                  first_ff   <= 1'b1;
                  is_read_ff <= 1'b1;
                  param_o    <= '{req: 1'b1, wr: 1'b0, addr: rq_addr, wdata: 16'h0000};
                  state_ff   <= S_RD_REQ;
               end
            end
            S_WRITE: begin
               if (param_rsp_i.ack) begin
                  param_o.req <= 1'b0;
                  if (param_rsp_i.exc != EXC_NONE) begin
                     hdr_ff     <= exc_hdr(hdr_ff[0], hdr_ff[1], param_rsp_i.exc);
                     hdr_len_ff <= SHORT_LEN;
                  end
                  state_ff <= bcast_ff ? S_IDLE : S_HDR;
               end
            end
            S_RD_REQ: begin
               if (param_rsp_i.ack) begin
                  param_o.req <= 1'b0;
                  word_ff     <= param_rsp_i.rdata;
                  words_ff    <= words_ff - 8'h01;
                  idx_ff      <= 3'h0;
                  if (first_ff && param_rsp_i.exc != EXC_NONE) begin
                     hdr_ff     <= exc_hdr(hdr_ff[0], hdr_ff[1], param_rsp_i.exc);
                     is_read_ff <= 1'b0;
                     state_ff   <= S_HDR;
                  end else begin
                     first_ff <= 1'b0;
                     state_ff <= first_ff ? S_HDR : S_RD_WORD;
                  end
               end
            end
            S_HDR: begin
               if (push) begin
                  if (idx_ff == hdr_len_ff - 3'h1) begin
                     idx_ff   <= 3'h0;
                     state_ff <= is_read_ff ? S_RD_WORD : S_CRC;
                  end else begin
                     idx_ff <= idx_ff + 3'h1;
                  end
               end
            end
            S_RD_WORD: begin
               if (push) begin
                  if (idx_ff == 3'h1) begin
                     idx_ff <= 3'h0;
                     if (words_ff == 8'h00) begin
                        state_ff <= S_CRC;
                     end else begin
                        param_o.req  <= 1'b1;
                        param_o.addr <= param_o.addr + 16'h0001;
                        state_ff     <= S_RD_REQ;
                     end
                  end else begin
                     idx_ff <= 3'h1;
                  end
               end
            end
            S_CRC: begin
               if (push) begin
                  idx_ff   <= (idx_ff == 3'h1) ? 3'h0 : 3'h1;
                  state_ff <= (idx_ff == 3'h1) ? S_DRAIN : S_CRC;
               end
            end
            S_DRAIN: begin
               if (buf_empty && tx_idle_i) begin
                  state_ff <= S_IDLE;
               end
            end
         endcase
      end
   end

   assign push_valid = state_ff == S_HDR || state_ff == S_RD_WORD || state_ff == S_CRC;
   assign push       = push_valid && buf_in_ready;

   always_comb begin
      unique case (state_ff)
         S_HDR:     push_byte = hdr_ff[idx_ff];
         S_RD_WORD: push_byte = (idx_ff == 3'h0) ? word_ff[15:8] : word_ff[7:0];
         S_CRC:     push_byte = (idx_ff == 3'h0) ? tx_crc_ff[7:0] : tx_crc_ff[15:8];
         default:   push_byte = 8'h00;
      endcase
   end

   // Reply checksum, restarted for every frame
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_crc_ff <= CRC_INIT;
      end else if (state_ff == S_IDLE || state_ff == S_EVAL) begin
         tx_crc_ff <= CRC_INIT;
      end else if (push && state_ff != S_CRC) begin
         tx_crc_ff <= crc_byte(tx_crc_ff, push_byte);
      end
   end

   // Line driver held from first reply byte until the transmitter is idle
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         drive_en_ff <= 1'b0;
      end else if (state_ff == S_HDR) begin
         drive_en_ff <= 1'b1;
      end else if (state_ff == S_DRAIN && buf_empty && tx_idle_i) begin
         drive_en_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_ok_ff <= 1'b0;
         crc_err_ff  <= 1'b0;
      end else begin
         frame_ok_ff <= state_ff == S_EVAL && accept;
         crc_err_ff  <= state_ff == S_EVAL && !crc_ok;
      end
   end

   assign drive_en_o = drive_en_ff;
   assign frame_ok_o = frame_ok_ff;
   assign crc_err_o  = crc_err_ff;

   // A stalled transmitter backs up into the sequencer instead of dropping bytes
   tx_skid_buf #(
      .WIDTH (8)
   ) u_tx_buf (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .in_valid_i  (push_valid),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (push_byte),
      .out_valid_o (tx_valid_o),
      .out_ready_i (tx_ready_i),
      .out_data_o  (tx_data_o),
      .empty_o     (buf_empty)
   );

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   drive_cover_a:  assert property (tx_valid_o |-> drive_en_o)
      else $error("byte offered without line drive");
   idle_quiet_a:   assert property (state_ff == S_IDLE |-> !push_valid ##1 !drive_en_o || state_ff != S_IDLE)
      else $error("transmit started without a request");
   bcast_mute_a:   assert property (state_ff == S_EVAL && accept && is_bcast |=> !drive_en_o [*3])
      else $error("reply to broadcast");
   drop_silent_a:  assert property (state_ff == S_EVAL && !accept |=> state_ff == S_IDLE ##1 !drive_en_o)
      else $error("rejected frame not dropped");
   crc_seed_a:     assert property (rx_start |=> rx_crc_ff == crc_byte(CRC_INIT, $past(rx_data_i)))
      else $error("receive checksum not seeded");
   gap_restart_a:  assert property (rx_valid_i |=> gap_cnt_ff == 8'h00)
      else $error("silence timer not restarted");
   abandon_part_a: assert property (rx_take && frame_open_ff && gap15 |=> rx_cnt_ff == 8'h01)
      else $error("partial frame not abandoned");
   crc_order_a:    assert property (push && state_ff == S_CRC && idx_ff == 3'h0
                                    |-> push_byte == tx_crc_ff[7:0] ##1 state_ff == S_CRC)
      else $error("check bytes out of order");
   exc_fn_a:       assert property (push && state_ff == S_HDR && idx_ff == 3'h1 && !is_read_ff
                                    && hdr_len_ff == SHORT_LEN |-> push_byte[7] == 1'b1)
      else $error("exception function lacks flag");
   rd_count_a:     assert property (state_ff == S_EVAL && accept && eval_code == EXC_NONE && !is_bcast
                                    && rx_buf_ff[1] == FN_READ |=> hdr_ff[2] == {$past(rq_val[6:0]), 1'b0})
      else $error("byte count not twice the quantity");

   read_reply_c:  cover property (state_ff == S_RD_WORD && push ##[1:40] state_ff == S_DRAIN);
   write_echo_c:  cover property (state_ff == S_WRITE && param_rsp_i.ack && param_rsp_i.exc == EXC_NONE && !bcast_ff);
   exception_c:   cover property (state_ff == S_EVAL && accept && eval_code != EXC_NONE && !is_bcast);
   abandon_c:     cover property (rx_take && frame_open_ff && gap15);

endmodule : modbus_rtu_slave_framer
`default_nettype wire

// ===== verif/uart_tx_model.sv
// Behavioural serial transmitter that drains reply bytes with random stalls
`timescale 1ns/1ps
`default_nettype none
module uart_tx_model #(
   parameter int SEED = 79
)(
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   // Byte stream from the frame engine
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   input  wire logic       drive_en_i,
   output logic            tx_ready_o,
   output logic            tx_idle_o,
   // Bytes as they go onto the line
   output logic            got_valid_o,
   output logic [7:0]      got_data_o
);
   int         seed = SEED;
   logic [3:0] busy_ff;
   logic       stall_ff;
   assign tx_idle_o  = (busy_ff == 4'h0);
   assign tx_ready_o = tx_idle_o && !stall_ff;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_ff     <= 4'h0;
         stall_ff    <= 1'b0;
         got_valid_o <= 1'b0;
         got_data_o  <= 8'h00;
      end else begin
         stall_ff    <= 1'($random(seed));
         got_valid_o <= tx_valid_i && tx_ready_o;
         // Shift time keeps idle low from the cycle after a take
         busy_ff     <= (tx_valid_i && tx_ready_o) ? 4'hc : busy_ff - {3'h0, busy_ff != 4'h0};
         // A byte offered with the driver off never reaches the line intact
         got_data_o  <= drive_en_i ? tx_data_i : ~tx_data_i;
      end
   end
endmodule : uart_tx_model
`default_nettype wire

// ===== verif/tb_modbus_rtu_slave_framer.sv
// Self-checking bench for the serial slave frame engine
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_rtu_slave_framer;
   import mb_pkg::*;
   typedef logic [7:0] bq_type[$];
   logic          mclk_i = 1'b0, rst_i = 1'b1, rx_valid_i = 1'b0;
   logic          tx_ready_i, tx_idle_i, tx_valid_o, drive_en_o, frame_ok_o, crc_err_o, got_v, last_w, ok_s, err_s;
   logic [7:0]    own_addr_i = 8'h11, rx_data_i = 8'h00, tx_data_o, got_d;
   logic [15:0]   last_a, last_d, half_div = 16'h0001;
   param_req_type param_o;
   param_rsp_type rsp = '0;
   int            seed = 79, miscompares = 0, n_compared = 0, nreq = 0;
   logic [7:0]    exc_q = 8'h00;
   bq_type        got;
   always #5 mclk_i = ~mclk_i;
   modbus_rtu_slave_framer dut (.mclk_i(mclk_i), .rst_i(rst_i), .own_addr_i(own_addr_i), .half_bit_div_i(half_div),
      .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
      .tx_ready_i(tx_ready_i), .tx_idle_i(tx_idle_i), .drive_en_o(drive_en_o), .param_o(param_o),
      .param_rsp_i(rsp), .frame_ok_o(frame_ok_o), .crc_err_o(crc_err_o));
   uart_tx_model peer (.mclk_i(mclk_i), .rst_i(rst_i), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
      .drive_en_i(drive_en_o), .tx_ready_o(tx_ready_i), .tx_idle_o(tx_idle_i), .got_valid_o(got_v), .got_data_o(got_d));
   // Parameter store: random ack delay, read value derived from the address
   always @(posedge mclk_i) begin
      rsp.ack   <= param_o.req && !rsp.ack && (($random(seed) & 3) == 0);
      rsp.exc   <= exc_q;
      rsp.rdata <= param_o.addr ^ 16'h5a5a;
      if (param_o.req && rsp.ack) begin
         last_w <= param_o.wr;
         last_a <= param_o.addr;
         last_d <= param_o.wdata;
         nreq   <= nreq + 1;
      end
      if (frame_ok_o) ok_s <= 1'b1;
      if (crc_err_o) err_s <= 1'b1;
      if (got_v) got.push_back(got_d);
   end
   function automatic bq_type seal(input bq_type q);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (q[i]) begin
         c ^= {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      return q;
   endfunction : seal
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic put(input logic [7:0] b);
      @(posedge mclk_i);
      rx_data_i  <= b;
      rx_valid_i <= 1'b1;
      @(posedge mclk_i);
      rx_valid_i <= 1'b0;
   endtask : put
   // Send one request, then stay quiet long past the frame gap
   task automatic run(input bq_type q, input bq_type exp, input logic ok, input logic err);
      int n;
      got.delete();
      ok_s  = 1'b0;
      err_s = 1'b0;
      foreach (q[i]) put(q[i]);
      n = 0;
      while (n < 3000 && got.size() < exp.size()) begin
         @(posedge mclk_i);
         n++;
      end
      repeat (300) @(posedge mclk_i);
      check(16'(got.size()), 16'(exp.size()));
      foreach (exp[i]) if (i < got.size()) check({8'h00, got[i]}, {8'h00, exp[i]});
      check({15'h0, ok_s}, {15'h0, ok});
      check({15'h0, err_s}, {15'h0, err});
      check({15'h0, drive_en_o}, 16'h0000);
      $display("test done: %0d bytes back", got.size());
   endtask : run
   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   initial begin
      #600000;
      miscompares++;
      end_sim();
   end
   initial begin
      bq_type      w, e;
      logic [15:0] a, d;
      logic [7:0]  f;
      int          n, r;
      logic [7:0]  codes[4];
      codes = '{EXC_BAD_FN, EXC_BAD_DAT, EXC_BAD_ADR, EXC_FAIL};
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         // Vary the baud divisor so gap timing must follow it
         half_div <= 16'(k + 1);
         a = 16'($random(seed));
         d = 16'($random(seed));
         w = seal('{own_addr_i, FN_WRITE, a[15:8], a[7:0], d[15:8], d[7:0]});
         run(w, w, 1'b1, 1'b0);
         check(last_a, a);
         check(last_d, d);
         check({15'h0, last_w}, 16'h0001);
         n = 1 + ($random(seed) & 3);
         e = '{own_addr_i, FN_READ, 8'(2 * n)};
         for (int i = 0; i < n; i++) e = {e, 8'((a + 16'(i)) >> 8) ^ 8'h5a, 8'(a + 16'(i)) ^ 8'h5a};
         run(seal('{own_addr_i, FN_READ, a[15:8], a[7:0], 8'h00, 8'(n)}), seal(e), 1'b1, 1'b0);
      end
      r = nreq;
      run(seal('{ADDR_BCAST, FN_WRITE, 8'h12, 8'h34, 8'hab, 8'hcd}), '{}, 1'b1, 1'b0);
      check(last_a, 16'h1234);
      run(seal('{own_addr_i + 8'h01, FN_WRITE, 8'h00, 8'h01, 8'h00, 8'h02}), '{}, 1'b0, 1'b0);
      check(16'(nreq - r), 16'h0001);
      w = seal('{own_addr_i, FN_WRITE, 8'h00, 8'h01, 8'h00, 8'h02});
      w[7] = ~w[7];
      run(w, '{}, 1'b0, 1'b1);
      w[7] = ~w[7];
      // Nonzero tail byte: a zero byte would leave the residue at zero
      run({w, 8'h5a}, '{}, 1'b0, 1'b1);
      put(8'h55);
      put(8'h03);
      // About 50 half-bit ticks: past 1.5 characters, short of 3.5
      repeat (50 * int'(half_div)) @(posedge mclk_i);
      run(w, w, 1'b1, 1'b0);
      w = seal('{own_addr_i, FN_WRITE, 8'h00});
      run(w, seal('{own_addr_i, FN_WRITE | EXC_FLAG, EXC_BAD_DAT}), 1'b1, 1'b0);
      for (int k = 0; k < 4; k++) begin
         exc_q = (k > 1) ? codes[k] : EXC_NONE;
         // Bad function, zero read count, then store errors on a read's first word and on a write
         f = (k == 0) ? 8'h10 : (k == 3) ? FN_WRITE : FN_READ;
         w = seal('{own_addr_i, f, 8'h00, 8'h01, 8'h00, 8'(k == 2)});
         run(w, seal('{own_addr_i, f | EXC_FLAG, codes[k]}), 1'b1, 1'b0);
      end
      end_sim();
   end
endmodule : tb_modbus_rtu_slave_framer
`default_nettype wire
